// *** pkg/dpsfe_pkg.sv ***
package dpsfe_pkg;

	// ------------------------------------------------------------
	// Asynchronous character timing; bit divisors and ATR delay in link clock periods
	// ------------------------------------------------------------
	localparam logic [15:0] ETU_DIV_0       = 16'd372;
	localparam logic [15:0] ETU_DIV_1       = 16'd186;
	localparam logic [15:0] ETU_DIV_2       = 16'd93;
	localparam logic [15:0] ETU_DIV_3       = 16'd32;
	localparam logic [15:0] ATR_DELAY_CLKS  = 16'd400;
	localparam logic [3:0]  FRAME_BITS      = 4'd10;
	localparam logic [3:0]  RX_SAMPLES      = 4'd9;
	localparam logic [3:0]  GUARD_ETU       = 4'd2;
	localparam logic [3:0]  ATR_BYTES       = 4'd8;
	localparam int          ATR_WIDTH       = 64;

	// ------------------------------------------------------------
	// Synchronous link framing
	// ------------------------------------------------------------
	localparam logic [3:0]  BYTE_BITS       = 4'd8;
	localparam int          DEV_ADDR_MSB    = 7;
	localparam int          DEV_ADDR_LSB    = 4;
	localparam int          RNW_BIT         = 0;
	localparam logic [3:0]  MAX_DEV_ADDR    = 4'hE;

	// ------------------------------------------------------------
	// User memory zones
	// ------------------------------------------------------------
	localparam int          MEM_ADDR_W      = 14;
	localparam int          ZONE_MSB        = 13;
	localparam int          ZONE_LSB        = 10;
	localparam int          ZONES           = 16;

	typedef struct packed {
		logic [7:0] data;
		logic       sync_mode;
	} dpsfe_word_t;

	typedef enum {
		A_OFF, A_HOLD, A_ATR_WAIT, A_TX, A_GUARD, A_READY,
		A_RX_HALF, A_RX_BITS, A_RX_END, A_RX_ERR
	} dpsfe_astate_t;

	typedef enum {
		S_IDLE, S_ADDR, S_ADDR_DONE, S_ACK, S_WR, S_WR_DONE,
		S_RD, S_RD_ACK, S_RD_NEXT
	} dpsfe_sstate_t;

endpackage

// *** hdl/dpsfe_front_end.sv ***
`timescale 1ns/1ps
// Overview of operation
// - Async bit lasts 372 link clock periods.
// - Sync: sample on rise, change on fall.
// - Reset release sends 64-bit answer-to-reset asynchronously.
// - No answer-to-reset in synchronous mode.
// - Reset pin idle high keeps synchronous mode.
// - Data pin only pulled low or released.
// - One data pin shared by both protocols.
// - Sync device answers only its own address.
// - Selectable faster bit rate, up to 153600 baud.
// - Sync clock up to 1 MHz handled.
// - Sixteen 1-Kbyte zones, each access-checked.
module dpsfe_front_end #(
	parameter int RXB_DEPTH = 2
) (
	input  wire logic                              core_clk,
	input  wire logic                              rst_b,
	input  wire logic                              link_clk,
	input  wire logic                              card_rst,
	input  wire logic                              sda_i,
	output wire logic                              sda_o,
	output wire logic                              sda_oe,
	input  wire logic [3:0]                        dev_addr,
	input  wire logic [1:0]                        etu_sel,
	input  wire logic [dpsfe_pkg::ATR_WIDTH-1:0]   atr_value,
	input  wire logic                              tx_valid,
	input  wire logic [7:0]                        tx_data,
	output wire logic                              tx_ready,
	output wire logic                              rx_valid,
	output dpsfe_pkg::dpsfe_word_t                 rx_word,
	input  wire logic                              rx_ready,
	output wire logic                              async_mode,
	input  wire logic [dpsfe_pkg::MEM_ADDR_W-1:0]  acc_addr,
	input  wire logic [dpsfe_pkg::ZONES-1:0]       zone_open,
	output logic                                   acc_grant
);

	// ------------------------------------------------------------
	// Pin synchronisers and edge finders
	// ------------------------------------------------------------
	logic l_s1, l_s2, l_s3;
	logic d_s1, d_s2, d_s3;
	logic r_s1, r_s2;
	logic l_rise, l_fall, start_cond, stop_cond;

	// Reset pin flops come up high: an unbonded pin reads as inactive
	// Clock flops come up at the idle level, so no false edge follows reset
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			l_s1 <= 1'b1;
			l_s2 <= 1'b1;
			l_s3 <= 1'b1;
			d_s1 <= 1'b1;
			d_s2 <= 1'b1;
			d_s3 <= 1'b1;
			r_s1 <= 1'b1;
			r_s2 <= 1'b1;
		end else begin
			l_s1 <= link_clk;
			l_s2 <= l_s1;
			l_s3 <= l_s2;
			d_s1 <= sda_i;
			d_s2 <= d_s1;
			d_s3 <= d_s2;
			r_s1 <= card_rst;
			r_s2 <= r_s1;
		end
	end

	assign l_rise     = l_s2 & ~l_s3;
	assign l_fall     = ~l_s2 & l_s3;
	assign start_cond = l_s2 & l_s3 & ~d_s2 & d_s3;
	assign stop_cond  = l_s2 & l_s3 & d_s2 & ~d_s3;

	function automatic logic [15:0] etu_div(input logic [1:0] sel);
		unique case (sel)
			2'h0: etu_div = dpsfe_pkg::ETU_DIV_0;
			2'h1: etu_div = dpsfe_pkg::ETU_DIV_1;
			2'h2: etu_div = dpsfe_pkg::ETU_DIV_2;
			2'h3: etu_div = dpsfe_pkg::ETU_DIV_3;
		endcase
	endfunction

	// ------------------------------------------------------------
	// Receive buffer
	// ------------------------------------------------------------
	localparam int PW = (RXB_DEPTH > 1) ? $clog2(RXB_DEPTH) : 1;
	dpsfe_pkg::dpsfe_word_t rxb_mem [RXB_DEPTH];
	logic [PW-1:0]          rxb_wr, rxb_rd;
	logic [PW:0]            rxb_cnt;
	logic                   rxb_push, rxb_pop, rxb_in_ready;
	dpsfe_pkg::dpsfe_word_t rxb_in;

	assign rxb_in_ready = (rxb_cnt != PW'(0) + (PW+1)'(RXB_DEPTH));
	assign rx_valid     = (rxb_cnt != '0);
	assign rxb_pop      = rx_valid & rx_ready;
	assign rx_word      = rxb_mem[rxb_rd];

	function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
		ptr_inc = (p == PW'(RXB_DEPTH - 1)) ? '0 : p + PW'(1);
	endfunction

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			rxb_wr  <= '0;
			rxb_rd  <= '0;
			rxb_cnt <= '0;
		end else begin
			if (rxb_push) begin
				rxb_mem[rxb_wr] <= rxb_in;
				rxb_wr          <= ptr_inc(rxb_wr);
			end
			if (rxb_pop)
				rxb_rd <= ptr_inc(rxb_rd);
			rxb_cnt <= rxb_cnt + (PW+1)'(rxb_push) - (PW+1)'(rxb_pop);
		end
	end

	// ------------------------------------------------------------
	// Asynchronous engine
	// ------------------------------------------------------------
	dpsfe_pkg::dpsfe_astate_t a_state;
	logic [15:0] a_cnt, a_div;
	logic [3:0]  a_bit, atr_idx;
	logic [9:0]  a_shift;
	logic        a_low, etu_end, half_end, atr_done, a_par_ok, a_pop, a_push;
	logic [7:0]  atr_byte;

	assign a_div    = etu_div(etu_sel);
	assign etu_end  = (a_cnt == a_div - 16'd1);
	assign half_end = (a_cnt == (a_div >> 1) - 16'd1);
	assign atr_done = (atr_idx == dpsfe_pkg::ATR_BYTES);
	assign atr_byte = atr_value[atr_idx[2:0]*8 +: 8];
	assign a_par_ok = ~^a_shift[9:1];
	assign a_pop    = l_rise & (a_state == dpsfe_pkg::A_READY) & atr_done & tx_valid;
	assign a_push   = l_rise & (a_state == dpsfe_pkg::A_RX_END) & etu_end & a_par_ok & rxb_in_ready;
	assign async_mode = (a_state != dpsfe_pkg::A_OFF);

	function automatic logic [9:0] frame_of(input logic [7:0] b);
		frame_of = {^b, b, 1'b0};
	endfunction

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			a_state <= dpsfe_pkg::A_OFF;
			a_low   <= 1'b0;
			a_cnt   <= '0;
			a_bit   <= '0;
			a_shift <= '0;
			atr_idx <= '0;
		end else if (!r_s2) begin
			a_state <= dpsfe_pkg::A_HOLD;
			a_low   <= 1'b0;
			a_cnt   <= '0;
			atr_idx <= '0;
		end else if (l_rise) begin
			a_cnt <= etu_end ? '0 : a_cnt + 16'd1;
			unique case (a_state)
				dpsfe_pkg::A_OFF: a_cnt <= '0;
				dpsfe_pkg::A_HOLD: begin
					a_cnt   <= '0;
					a_state <= dpsfe_pkg::A_ATR_WAIT;
				end
				dpsfe_pkg::A_ATR_WAIT: begin
					a_cnt <= a_cnt + 16'd1;
					if (a_cnt == dpsfe_pkg::ATR_DELAY_CLKS - 16'd1) begin
						a_cnt   <= '0;
						a_state <= dpsfe_pkg::A_READY;
					end
				end
				dpsfe_pkg::A_READY: begin
					a_cnt <= '0;
					a_bit <= '0;
					if (!atr_done) begin
						a_shift <= frame_of(atr_byte);
						atr_idx <= atr_idx + 4'd1;
						a_low   <= 1'b1;
						a_state <= dpsfe_pkg::A_TX;
					end else if (tx_valid) begin
						a_shift <= frame_of(tx_data);
						a_low   <= 1'b1;
						a_state <= dpsfe_pkg::A_TX;
					end else if (!d_s2) begin
						a_state <= dpsfe_pkg::A_RX_HALF;
					end
				end
				dpsfe_pkg::A_TX: if (etu_end) begin
					if (a_bit == dpsfe_pkg::FRAME_BITS - 4'd1) begin
						a_low   <= 1'b0;
						a_bit   <= '0;
						a_state <= dpsfe_pkg::A_GUARD;
					end else begin
						a_low   <= ~a_shift[1];
						a_shift <= a_shift >> 1;
						a_bit   <= a_bit + 4'd1;
					end
				end
				dpsfe_pkg::A_GUARD: if (etu_end) begin
					a_bit <= a_bit + 4'd1;
					if (a_bit == dpsfe_pkg::GUARD_ETU - 4'd1)
						a_state <= dpsfe_pkg::A_READY;
				end
				dpsfe_pkg::A_RX_HALF: if (half_end) begin
					a_cnt   <= '0;
					a_bit   <= '0;
					a_state <= dpsfe_pkg::A_RX_BITS;
				end
				dpsfe_pkg::A_RX_BITS: if (etu_end) begin
					a_shift <= {d_s2, a_shift[9:1]};
					a_bit   <= a_bit + 4'd1;
					if (a_bit == dpsfe_pkg::RX_SAMPLES - 4'd1)
						a_state <= dpsfe_pkg::A_RX_END;
				end
				// Bad parity or a full buffer asks the reader to repeat
				dpsfe_pkg::A_RX_END: if (etu_end) begin
					if (a_par_ok && rxb_in_ready) begin
						a_bit   <= dpsfe_pkg::GUARD_ETU - 4'd1;
						a_state <= dpsfe_pkg::A_GUARD;
					end else begin
						a_low   <= 1'b1;
						a_state <= dpsfe_pkg::A_RX_ERR;
					end
				end
				dpsfe_pkg::A_RX_ERR: if (etu_end) begin
					a_low   <= 1'b0;
					a_bit   <= '0;
					a_state <= dpsfe_pkg::A_GUARD;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Synchronous engine
	// ------------------------------------------------------------
	dpsfe_pkg::dpsfe_sstate_t s_state;
	logic [7:0] s_shift;
	logic [3:0] s_cnt;
	logic       s_rnw, s_low, s_act, s_match, s_push, s_pop;

	assign s_act   = ~async_mode;
	assign s_match = (s_shift[dpsfe_pkg::DEV_ADDR_MSB:dpsfe_pkg::DEV_ADDR_LSB] == dev_addr)
	               & (dev_addr <= dpsfe_pkg::MAX_DEV_ADDR);
	assign s_push  = s_act & l_fall & (s_state == dpsfe_pkg::S_WR_DONE) & rxb_in_ready;
	assign s_pop   = s_act & l_fall & tx_valid
	               & ((s_state == dpsfe_pkg::S_ACK & s_rnw) | (s_state == dpsfe_pkg::S_RD_NEXT));

	// Edges are core-clock sampled, so a 1 MHz link clock gives ten samples
	always_ff @(posedge core_clk) begin
		if (!rst_b || !s_act) begin
			s_state <= dpsfe_pkg::S_IDLE;
			s_low   <= 1'b0;
			s_cnt   <= '0;
			s_rnw   <= 1'b0;
			s_shift <= '0;
		end else if (stop_cond) begin
			s_state <= dpsfe_pkg::S_IDLE;
			s_low   <= 1'b0;
		end else if (start_cond) begin
			s_state <= dpsfe_pkg::S_ADDR;
			s_low   <= 1'b0;
			s_cnt   <= '0;
		end else if (l_rise) begin
			unique case (s_state)
				dpsfe_pkg::S_ADDR, dpsfe_pkg::S_WR: begin
					s_shift <= {s_shift[6:0], d_s2};
					s_cnt   <= s_cnt + 4'd1;
					if (s_cnt == dpsfe_pkg::BYTE_BITS - 4'd1)
						s_state <= (s_state == dpsfe_pkg::S_ADDR) ? dpsfe_pkg::S_ADDR_DONE
						                                          : dpsfe_pkg::S_WR_DONE;
				end
				dpsfe_pkg::S_RD_ACK: s_state <= d_s2 ? dpsfe_pkg::S_IDLE : dpsfe_pkg::S_RD_NEXT;
				default: ;
			endcase
		end else if (l_fall) begin
			unique case (s_state)
				dpsfe_pkg::S_ADDR_DONE: begin
					s_rnw   <= s_shift[dpsfe_pkg::RNW_BIT];
					s_low   <= s_match;
					s_state <= s_match ? dpsfe_pkg::S_ACK : dpsfe_pkg::S_IDLE;
				end
				dpsfe_pkg::S_WR_DONE: begin
					s_rnw   <= 1'b0;
					s_low   <= rxb_in_ready;
					s_state <= rxb_in_ready ? dpsfe_pkg::S_ACK : dpsfe_pkg::S_IDLE;
				end
				dpsfe_pkg::S_ACK, dpsfe_pkg::S_RD_NEXT: begin
					s_cnt <= 4'd1;
					if (s_state == dpsfe_pkg::S_ACK && !s_rnw) begin
						s_low   <= 1'b0;
						s_cnt   <= '0;
						s_state <= dpsfe_pkg::S_WR;
					end else if (tx_valid) begin
						s_low   <= ~tx_data[7];
						s_shift <= {tx_data[6:0], 1'b0};
						s_state <= dpsfe_pkg::S_RD;
					end else begin
						s_low   <= 1'b0;
						s_state <= dpsfe_pkg::S_IDLE;
					end
				end
				dpsfe_pkg::S_RD: begin
					if (s_cnt == dpsfe_pkg::BYTE_BITS) begin
						s_low   <= 1'b0;
						s_state <= dpsfe_pkg::S_RD_ACK;
					end else begin
						s_low   <= ~s_shift[7];
						s_shift <= s_shift << 1;
						s_cnt   <= s_cnt + 4'd1;
					end
				end
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Shared pin, streams and zone check
	// ------------------------------------------------------------
	assign sda_o    = 1'b0;
	assign sda_oe   = a_low | s_low;
	assign tx_ready = a_pop | s_pop;
	assign rxb_push = a_push | s_push;
	assign rxb_in   = a_push ? dpsfe_pkg::dpsfe_word_t'{data: a_shift[8:1], sync_mode: 1'b0}
	                         : dpsfe_pkg::dpsfe_word_t'{data: s_shift, sync_mode: 1'b1};

	always_ff @(posedge core_clk) begin
		if (!rst_b)
			acc_grant <= 1'b0;
		else
			acc_grant <= zone_open[acc_addr[dpsfe_pkg::ZONE_MSB:dpsfe_pkg::ZONE_LSB]];
	end

endmodule

// *** dv/dpsfe_front_end_assertions.sv ***
`timescale 1ns/1ps
module dpsfe_front_end_checker (
	input wire logic                       core_clk,
	input wire logic                       rst_b,
	input wire logic                       link_clk,
	input wire logic                       card_rst,
	input wire logic                       sda_o,
	input wire logic                       sda_oe,
	input wire logic                       tx_valid,
	input wire logic                       tx_ready,
	input wire logic                       rx_valid,
	input wire dpsfe_pkg::dpsfe_word_t     rx_word,
	input wire logic                       rx_ready,
	input wire logic                       async_mode,
	input wire logic [13:0]                acc_addr,
	input wire logic [15:0]                zone_open,
	input wire logic                       acc_grant
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	// ----
	// Port relations
	// ----
	a_grant_zone: assert property ($past(rst_b) |-> acc_grant == $past(zone_open[acc_addr[13:10]]))
		else $error("acc_grant does not follow zone bit");
	a_pin_low_only: assert property (sda_o == 1'b0)
		else $error("data pin driven high");
	a_reset_quiet: assert property (!$past(rst_b) |-> !sda_oe && !rx_valid && !async_mode && !acc_grant)
		else $error("outputs not quiet after reset");
	a_sync_stays: assert property (card_rst [*6] ##0 !async_mode |=> !async_mode)
		else $error("async mode entered with reset pin high");
	a_mode_latched: assert property (async_mode |=> async_mode)
		else $error("async mode dropped");
	a_hold_released: assert property (!card_rst [*6] |-> !sda_oe)
		else $error("pin driven while host holds reset");
	a_sync_on_fall: assert property (!async_mode && !$past(async_mode) && $changed(sda_oe) |-> !$past(link_clk, 2))
		else $error("sync output changed outside clock low");
	a_tx_offer: assert property (tx_ready |-> tx_valid ##1 !tx_ready)
		else $error("tx_ready without offer or held");
	a_rx_hold: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_word))
		else $error("rx word lost while stalled");
endmodule
bind dpsfe_front_end dpsfe_front_end_checker chk (.core_clk(core_clk), .rst_b(rst_b), .link_clk(link_clk),
	.card_rst(card_rst), .sda_o(sda_o), .sda_oe(sda_oe), .tx_valid(tx_valid), .tx_ready(tx_ready),
	.rx_valid(rx_valid), .rx_word(rx_word), .rx_ready(rx_ready), .async_mode(async_mode),
	.acc_addr(acc_addr), .zone_open(zone_open), .acc_grant(acc_grant));

// *** dv/dpsfe_host_model.sv ***
`timescale 1ns/1ps
module dpsfe_host_model (
	output logic      link_clk,
	output logic      card_rst,
	output logic      host_low,
	input  wire logic sda
);
	int   etu = 32;
	logic run = 1'b0;
	initial begin
		link_clk = 1'b1;
		card_rst = 1'b1;
		host_low = 1'b0;
	end
	// Carrier runs only in async sessions; sync clock stands high between frames
	always begin
		#400;
		if (run) link_clk = ~link_clk;
	end
	task automatic sync_start();
		host_low = 1'b1;
		#400 link_clk = 1'b0;
	endtask
	task automatic sync_stop();
		host_low = 1'b1;
		#400 link_clk = 1'b1;
		#400 host_low = 1'b0;
		#400;
	endtask
	task automatic sync_bit(input logic b, output logic s);
		host_low = ~b;
		#400 link_clk = 1'b1;
		#300 s = sda;
		#100 link_clk = 1'b0;
	endtask
	task automatic sync_byte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) sync_bit(d[i], s);
		sync_bit(1'b1, ack);
	endtask
	task automatic sync_read(input logic more, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) sync_bit(1'b1, d[i]);
		sync_bit(~more, s);
	endtask
	task automatic async_get(output logic [7:0] d, output logic p);
		logic [8:0] b;
		// A low parity bit of the previous char must not pass for a start bit
		while (sda !== 1'b1) @(posedge link_clk);
		do @(posedge link_clk); while (sda !== 1'b0);
		repeat (etu / 2) @(posedge link_clk);
		for (int i = 0; i < 9; i++) begin
			repeat (etu) @(posedge link_clk);
			b[i] = sda;
		end
		{p, d} = b;
	endtask
	task automatic async_put(input logic [7:0] d);
		logic [9:0] f;
		f = {^d, d, 1'b0};
		// Rest of the last char plus its two ETU of guard
		repeat (3 * etu) @(posedge link_clk);
		for (int i = 0; i < 10; i++) begin
			host_low = ~f[i];
			repeat (etu) @(posedge link_clk);
		end
		host_low = 1'b0;
	endtask
endmodule

// *** dv/testbench.sv ***
`timescale 1ns/1ps
module testbench;
	logic                   core_clk = 1'b0;
	logic                   rst_b = 1'b0;
	logic [3:0]             dev_addr = 4'h0;
	logic [1:0]             etu_sel = 2'h3;
	logic [63:0]            atr_value = 64'h0;
	logic                   tx_valid = 1'b0;
	logic [7:0]             tx_data = 8'h00;
	logic                   rx_ready = 1'b0;
	logic [13:0]            acc_addr = 14'h0000;
	logic [15:0]            zone_open = 16'h0000;
	logic                   link_clk, card_rst, host_low, sda_o, sda_oe;
	logic                   tx_ready, rx_valid, async_mode, acc_grant;
	dpsfe_pkg::dpsfe_word_t rx_word;
	wire logic              sda = ~(sda_oe | host_low);
	logic [31:0]            seed = 32'h05EE2AA3;
	int                     n_errors = 0;
	int                     checked = 0;
	always #50 core_clk = ~core_clk;
	always @(posedge core_clk) if (tx_ready) tx_valid <= 1'b0;
	dpsfe_host_model host (.link_clk(link_clk), .card_rst(card_rst), .host_low(host_low), .sda(sda));
	dpsfe_front_end dut (.core_clk(core_clk), .rst_b(rst_b), .link_clk(link_clk), .card_rst(card_rst),
		.sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .dev_addr(dev_addr), .etu_sel(etu_sel),
		.atr_value(atr_value), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
		.rx_valid(rx_valid), .rx_word(rx_word), .rx_ready(rx_ready), .async_mode(async_mode),
		.acc_addr(acc_addr), .zone_open(zone_open), .acc_grant(acc_grant));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask
	task automatic final_report();
		$display("checks=%0d mismatches=%0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// Whole run needs about 70k cycles
	initial begin
		#9000000;
		n_errors++;
		final_report();
	end
	initial begin
		logic       ack;
		logic [7:0] d [3];
		logic [7:0] b;
		logic       p;
		host.etu = dpsfe_pkg::ETU_DIV_3;
		repeat (12) @(negedge core_clk);
		rst_b = 1'b1;
		repeat (3) @(negedge core_clk);
		check({sda_oe, rx_valid, async_mode, acc_grant}, 4'h0);
		for (int i = 0; i < 24; i++) begin
			acc_addr = (i == 0) ? 14'h3FFF : 14'(rnd());
			zone_open = (i == 0) ? 16'h7FFF : 16'(rnd());
			@(negedge core_clk);
			check(acc_grant, zone_open[acc_addr[13:10]]);
		end
		$display("zone test done");
		dev_addr = 4'(rnd() % 15);
		host.sync_start();
		host.sync_byte({dev_addr ^ 4'h1, 4'h0}, ack);
		check(ack, 1'b1);
		host.sync_stop();
		host.sync_start();
		host.sync_byte({dev_addr, 4'h0}, ack);
		check(ack, 1'b0);
		// Third byte finds the two-entry buffer full
		for (int i = 0; i < 3; i++) begin
			d[i] = 8'(rnd());
			host.sync_byte(d[i], ack);
			check(ack, i == 2);
		end
		host.sync_stop();
		for (int i = 0; i < 2; i++) begin
			@(negedge core_clk);
			check({rx_valid, rx_word}, {1'b1, d[i], 1'b1});
			rx_ready = 1'b1;
			@(negedge core_clk);
			rx_ready = 1'b0;
		end
		@(negedge core_clk);
		check(rx_valid, 1'b0);
		tx_data = 8'(rnd());
		tx_valid = 1'b1;
		host.sync_start();
		host.sync_byte({dev_addr, 4'h1}, ack);
		check(ack, 1'b0);
		host.sync_read(1'b0, b);
		check({tx_valid, b}, {1'b0, tx_data});
		host.sync_stop();
		$display("sync test done");
		atr_value = {rnd(), rnd()};
		host.run = 1'b1;
		host.card_rst = 1'b0;
		repeat (10) @(negedge core_clk);
		host.card_rst = 1'b1;
		check(async_mode, 1'b1);
		for (int i = 0; i < 8; i++) begin
			host.async_get(b, p);
			check({p, b}, {^atr_value[8*i+:8], atr_value[8*i+:8]});
		end
		@(negedge core_clk);
		tx_data = 8'(rnd());
		tx_valid = 1'b1;
		host.async_get(b, p);
		check({p, b}, {^tx_data, tx_data});
		b = 8'(rnd());
		host.async_put(b);
		for (int k = 0; k < 2000 && rx_valid !== 1'b1; k++) @(negedge core_clk);
		check({rx_valid, rx_word}, {1'b1, b, 1'b0});
		etu_sel = 2'h0;
		host.etu = dpsfe_pkg::ETU_DIV_0;
		tx_data = 8'(rnd());
		tx_valid = 1'b1;
		host.async_get(b, p);
		check({p, b}, {^tx_data, tx_data});
		$display("async test done");
		final_report();
	end
endmodule
